// ### design/dlrx_params.svh
// offsets, field positions, reset values and counts of the receive status monitor
`ifndef DLRX_PARAMS_SVH
`define DLRX_PARAMS_SVH

// observation bus span and bit positions
`define DLRX_OBS_LSB      296
`define DLRX_OBS_MSB      319
`define DLRX_OBS_TIMER    296
`define DLRX_OBS_ACKTO    297
`define DLRX_OBS_ACKREQ   298
`define DLRX_OBS_ACKTYPE  299
`define DLRX_OBS_PM       300
`define DLRX_OBS_FC       301
`define DLRX_OBS_FCTYP_LO 302
`define DLRX_OBS_FCTYP_HI 305
`define DLRX_OBS_VC_LO    306
`define DLRX_OBS_VC_HI    308
`define DLRX_OBS_NULL     309
`define DLRX_OBS_CRCERR   310
`define DLRX_OBS_GOOD     311
`define DLRX_OBS_DUP      312
`define DLRX_OBS_AHEAD    313
`define DLRX_OBS_FRAME    314
`define DLRX_OBS_CNT_LO   315
`define DLRX_OBS_CNT_HI   319

// register byte offsets
`define DLRX_REG_CTRL     8'h00
`define DLRX_REG_ACKLAT   8'h04
`define DLRX_REG_STATUS   8'h08
`define DLRX_REG_CLEAR    8'h0C
`define DLRX_REG_IRQEN    8'h10
`define DLRX_REG_OBS      8'h14
`define DLRX_REG_SEQ      8'h18

// control fields and reset values
`define DLRX_CTRL_EN      0
`define DLRX_CTRL_RST     1'h1
`define DLRX_ACKLAT_RST   16'h0100
`define DLRX_IRQEN_RST    8'h00

// status bit positions
`define DLRX_ST_NULL      0
`define DLRX_ST_CRCERR    1
`define DLRX_ST_DUP       2
`define DLRX_ST_AHEAD     3
`define DLRX_ST_FRAME     4
`define DLRX_ST_ACKTO     5
`define DLRX_ST_PM        6
`define DLRX_ST_FC        7
`define DLRX_ST_WIDTH     8

// link packet type byte decoding and retry count saturation value
`define DLRX_PM_PREFIX    5'h04
`define DLRX_RETRY_SAT    5'h1F

`endif

// ### design/dlrx_pkg.sv
// types shared by the receive status monitor
package dlrx_pkg;

    typedef enum logic [2:0] {
        ACK_IDLE    = 3'b001,
        ACK_TIMING  = 3'b010,
        ACK_PENDING = 3'b100
    } dlrx_ackst_t;

    typedef enum logic [1:0] {
        TLP_GOOD  = 2'h0,
        TLP_DUP   = 2'h1,
        TLP_AHEAD = 2'h2
    } dlrx_seqcls_t;

endpackage

// ### design/dlrx_sat_counter.sv
// up/down occupancy counter with a saturated report
`include "dlrx_params.svh"
module dlrx_sat_counter
    import dlrx_pkg::*;
#(
    parameter int CNT_W = 12
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    input  wire logic             incr,
    input  wire logic             decr,
    output logic      [4:0]       satCount_q
);

    if (CNT_W < 5) begin : g_chk
        $error("dlrx_sat_counter: CNT_W must be at least 5");
    end

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    wire              atZero = (count_q == '0);
    wire              atMax  = (count_q == {CNT_W{1'b1}});
    wire              bigVal = (count_q > CNT_W'(`DLRX_RETRY_SAT));

    // a push and a release in the same cycle cancel out
    assign count_d = (incr && !decr && !atMax) ? count_q + CNT_W'(1) :
                     (decr && !incr && !atZero) ? count_q - CNT_W'(1) : count_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q    <= '0;
            satCount_q <= 5'h00;
        end else if (clkEn) begin
            count_q    <= count_d;
            satCount_q <= bigVal ? `DLRX_RETRY_SAT : count_q[4:0]; // R16
        end
    end

endmodule

// ### design/dlrx_status_monitor.sv
// receive side data link status monitor with observation bus and apb registers
// Contract
// R01 - bit 296 high while ack timer runs
// R02 - timer expiry schedules ack, pulses bit 297
// R03 - bit 298 high while ack request pending
// R04 - bit 299 one means negative acknowledge
// R05 - bit 299 zero means positive acknowledge
// R06 - power packet sets bit 300, subtype in channel
// R07 - credit packet sets bit 301 with type, channel
// R08 - credit type field encodings on 305:302
// R09 - credit channel number binary on 308:306
// R10 - nullified transaction packet flagged on 309
// R11 - crc failing transaction packet flagged on 310
// R12 - good in-order packet flagged 311, forwarded
// R13 - duplicate flagged 312, dropped silently
// R14 - sequence ahead flagged 313 as error
// R15 - framing error: 314, port error, retrain
// R16 - retry buffer count on 319:315, saturates 31
`include "dlrx_params.svh"
module dlrx_status_monitor
    import dlrx_pkg::*;
#(
    parameter int SEQ_W   = 12,
    parameter int RETRY_W = 12
) (
    input  wire logic                                  clk_sys,
    input  wire logic                                  reset_n,
    input  wire logic                                  clkEn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [7:0]                            paddr,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    output logic                                       irq,
    input  wire logic                                  rxDllpValid,
    input  wire logic [7:0]                            rxDllpType,
    input  wire logic                                  rxTlpEnd,
    input  wire logic                                  rxTlpNullified,
    input  wire logic                                  rxTlpCrcOk,
    input  wire logic [SEQ_W-1:0]                      rxTlpSeq,
    input  wire logic                                  rxFrameError,
    input  wire logic                                  ackTxDone,
    input  wire logic                                  retryStore,
    input  wire logic                                  retryRelease,
    output logic                                       ackTxReq,
    output logic                                       ackTxNak,
    output logic                                       tlpForward,
    output logic                                       rxPortError,
    output logic                                       retrainReq,
    output logic      [`DLRX_OBS_MSB:`DLRX_OBS_LSB]    obsBus
);

    if (SEQ_W < 2 || SEQ_W > 32) begin : g_chk_seq
        $error("dlrx_status_monitor: SEQ_W out of range");
    end

    // sequence distance test: behind by up to half the space is a replay
    function automatic dlrx_seqcls_t seqClass(input logic [SEQ_W-1:0] expSeq,
                                              input logic [SEQ_W-1:0] gotSeq);
        logic [SEQ_W-1:0] behind;
        behind = expSeq - gotSeq;
        if (behind == '0) begin
            seqClass = TLP_GOOD;
        end else if (!behind[SEQ_W-1] || behind == {1'b1, {(SEQ_W-1){1'b0}}}) begin
            seqClass = TLP_DUP;
        end else begin
            seqClass = TLP_AHEAD;
        end
    endfunction

    function automatic logic regHit(input logic [7:0] addr, input logic [7:0] offs);
        regHit = (addr == offs);
    endfunction

    // ---------------- apb slave ----------------
    logic        ctrlEn_q;
    logic [15:0] ackLat_q;
    logic [`DLRX_ST_WIDTH-1:0] status_q;
    logic [`DLRX_ST_WIDTH-1:0] status_d;
    logic [`DLRX_ST_WIDTH-1:0] irqEn_q;
    logic [`DLRX_ST_WIDTH-1:0] stEvent;
    logic [SEQ_W-1:0]          expSeq_q;
    logic [31:0]               rdMux;

    wire setupPh   = psel && !penable && !pready;
    wire accessEnd = psel && penable && pready;
    wire hitCtrl   = regHit(paddr, `DLRX_REG_CTRL);
    wire hitAckLat = regHit(paddr, `DLRX_REG_ACKLAT);
    wire hitStatus = regHit(paddr, `DLRX_REG_STATUS);
    wire hitClear  = regHit(paddr, `DLRX_REG_CLEAR);
    wire hitIrqEn  = regHit(paddr, `DLRX_REG_IRQEN);
    wire hitObs    = regHit(paddr, `DLRX_REG_OBS);
    wire hitSeq    = regHit(paddr, `DLRX_REG_SEQ);
    wire mapped    = hitCtrl | hitAckLat | hitStatus | hitClear | hitIrqEn | hitObs | hitSeq;
    // status and observation words are read only; writes to them are errors
    wire wrLegal   = hitCtrl | hitAckLat | hitClear | hitIrqEn;
    wire rdLegal   = mapped && !hitClear;
    wire reqErr    = pwrite ? !wrLegal : !rdLegal;
    wire wrStrobe  = accessEnd && pwrite && !pslverr;
    wire wrCtrl    = wrStrobe && hitCtrl;
    wire wrAckLat  = wrStrobe && hitAckLat;
    wire wrClear   = wrStrobe && hitClear;
    wire wrIrqEn   = wrStrobe && hitIrqEn;

    assign rdMux = hitCtrl   ? {31'h0, ctrlEn_q} :
                   hitAckLat ? {16'h0, ackLat_q} :
                   hitStatus ? {{(32-`DLRX_ST_WIDTH){1'b0}}, status_q} :
                   hitIrqEn  ? {{(32-`DLRX_ST_WIDTH){1'b0}}, irqEn_q} :
                   hitObs    ? {8'h00, obsBus} :
                   hitSeq    ? 32'(expSeq_q) : 32'h0000_0000;

    // answer is prepared in the setup cycle so every bus output is a flop
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clkEn) begin
            pready  <= setupPh;
            pslverr <= setupPh && reqErr;
            prdata  <= (setupPh && !pwrite && rdLegal) ? rdMux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrlEn_q <= `DLRX_CTRL_RST;
            ackLat_q <= `DLRX_ACKLAT_RST;
            irqEn_q  <= `DLRX_IRQEN_RST;
        end else if (clkEn) begin
            if (wrCtrl)   ctrlEn_q <= pwdata[`DLRX_CTRL_EN];
            if (wrAckLat) ackLat_q <= pwdata[15:0];
            if (wrIrqEn)  irqEn_q  <= pwdata[`DLRX_ST_WIDTH-1:0];
        end
    end

    // ---------------- receive classification ----------------
    // with the monitor disabled received traffic is neither checked nor acknowledged
    wire rxOn      = ctrlEn_q;
    wire dllpSeen  = rxOn && rxDllpValid;
    wire [3:0] dllpHi = rxDllpType[7:4];
    wire fcCode    = (dllpHi == 4'h4) || (dllpHi == 4'h5) || (dllpHi == 4'h6) ||
                     (dllpHi == 4'h8) || (dllpHi == 4'h9) || (dllpHi == 4'hA) ||
                     (dllpHi == 4'hC) || (dllpHi == 4'hD) || (dllpHi == 4'hE);
    wire pmSub     = (rxDllpType[2:0] == 3'h0) || (rxDllpType[2:0] == 3'h1) ||
                     (rxDllpType[2:0] == 3'h3) || (rxDllpType[2:0] == 3'h4);
    wire powerPacketReceived  = dllpSeen && (rxDllpType[7:3] == `DLRX_PM_PREFIX) && pmSub;
    wire creditPacketReceived = dllpSeen && fcCode && !rxDllpType[3];
    wire [3:0] creditPacketType    = dllpHi;
    wire [2:0] creditChannelNumber = rxDllpType[2:0];

    wire          tlpSeen  = rxOn && rxTlpEnd;
    dlrx_seqcls_t seqCls;
    assign seqCls = seqClass(expSeq_q, rxTlpSeq);
    wire tlpNull   = tlpSeen && rxTlpNullified;
    wire tlpBadCrc = tlpSeen && !rxTlpNullified && !rxTlpCrcOk;
    wire tlpCrcOk  = tlpSeen && !rxTlpNullified && rxTlpCrcOk;
    wire tlpGood   = tlpCrcOk && (seqCls == TLP_GOOD);
    wire tlpDup    = tlpCrcOk && (seqCls == TLP_DUP);
    wire tlpAhead  = tlpCrcOk && (seqCls == TLP_AHEAD);
    wire frameErr  = rxOn && rxFrameError;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            expSeq_q <= '0;
        end else if (clkEn && tlpGood) begin
            expSeq_q <= expSeq_q + SEQ_W'(1);
        end
    end

    // ---------------- acknowledge scheduling ----------------
    dlrx_ackst_t ackSt_q;
    dlrx_ackst_t ackSt_d;
    logic [15:0] latCnt_q;
    logic        ackNak_q;
    logic        ackNak_d;
    // a bad packet needs a negative acknowledge without waiting on the timer
    wire needNak   = tlpBadCrc || tlpAhead;
    wire latExpire = (ackSt_q == ACK_TIMING) && (latCnt_q >= ackLat_q);
    // a duplicate still calls for an acknowledge so the sender can purge
    wire ackOwed   = tlpGood || tlpDup;

    always_comb begin
        ackSt_d  = ackSt_q;
        ackNak_d = ackNak_q;
        unique case (ackSt_q)
            ACK_IDLE: begin
                if (needNak) begin
                    ackSt_d  = ACK_PENDING;
                    ackNak_d = 1'b1; // R04
                end else if (ackOwed) begin
                    ackSt_d  = ACK_TIMING;
                    ackNak_d = 1'b0; // R05
                end
            end
            ACK_TIMING: begin
                if (needNak) begin
                    ackSt_d  = ACK_PENDING;
                    ackNak_d = 1'b1; // R04
                end else if (latExpire) begin
                    ackSt_d = ACK_PENDING; // R02
                end
            end
            ACK_PENDING: begin
                if (needNak) begin
                    ackNak_d = 1'b1; // R04
                end else if (ackTxDone) begin
                    ackSt_d  = ACK_IDLE;
                    ackNak_d = 1'b0; // R05
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ackSt_q  <= ACK_IDLE;
            ackNak_q <= 1'b0;
            latCnt_q <= 16'h0000;
        end else if (clkEn) begin
            ackSt_q  <= ackSt_d;
            ackNak_q <= ackNak_d;
            latCnt_q <= (ackSt_d == ACK_TIMING && ackSt_q == ACK_TIMING) ?
                        latCnt_q + 16'h0001 : 16'h0000;
        end
    end

    // ---------------- retry buffer occupancy ----------------
    logic [4:0] retryCount;

    dlrx_sat_counter #(
        .CNT_W      (RETRY_W)
    ) u_retry_cnt (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .clkEn      (clkEn),
        .incr       (retryStore),
        .decr       (retryRelease),
        .satCount_q (retryCount)
    );

    // ---------------- observation bus ----------------
    logic [`DLRX_OBS_MSB:`DLRX_OBS_LSB] obsD;

    always_comb begin
        obsD = '0;
        obsD[`DLRX_OBS_TIMER]   = (ackSt_q == ACK_TIMING); // R01
        obsD[`DLRX_OBS_ACKTO]   = latExpire && !needNak; // R02
        obsD[`DLRX_OBS_ACKREQ]  = (ackSt_q == ACK_PENDING); // R03
        obsD[`DLRX_OBS_ACKTYPE] = ackNak_q; // R04
        obsD[`DLRX_OBS_PM]      = powerPacketReceived; // R06
        obsD[`DLRX_OBS_FC]      = creditPacketReceived; // R07
        if (creditPacketReceived) begin
            obsD[`DLRX_OBS_FCTYP_HI:`DLRX_OBS_FCTYP_LO] = creditPacketType; // R08
        end
        // power packets reuse the channel field for their subtype
        if (creditPacketReceived || powerPacketReceived) begin
            obsD[`DLRX_OBS_VC_HI:`DLRX_OBS_VC_LO] = creditChannelNumber; // R09
        end
        obsD[`DLRX_OBS_NULL]    = tlpNull; // R10
        obsD[`DLRX_OBS_CRCERR]  = tlpBadCrc; // R11
        obsD[`DLRX_OBS_GOOD]    = tlpGood; // R12
        obsD[`DLRX_OBS_DUP]     = tlpDup; // R13
        obsD[`DLRX_OBS_AHEAD]   = tlpAhead; // R14
        obsD[`DLRX_OBS_FRAME]   = frameErr; // R15
        obsD[`DLRX_OBS_CNT_HI:`DLRX_OBS_CNT_LO] = retryCount; // R16
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            obsBus      <= '0;
            ackTxReq    <= 1'b0;
            ackTxNak    <= 1'b0;
            tlpForward  <= 1'b0;
            rxPortError <= 1'b0;
            retrainReq  <= 1'b0;
        end else if (clkEn) begin
            obsBus      <= obsD;
            ackTxReq    <= (ackSt_d == ACK_PENDING); // R03
            ackTxNak    <= ackNak_d; // R04
            tlpForward  <= tlpGood; // R12
            // a duplicate is dropped without any error indication
            rxPortError <= frameErr || tlpAhead || tlpBadCrc; // R13 R15
            retrainReq  <= frameErr; // R15
        end
    end

    // ---------------- sticky status and interrupt ----------------
    always_comb begin
        stEvent = '0;
        stEvent[`DLRX_ST_NULL]   = tlpNull;
        stEvent[`DLRX_ST_CRCERR] = tlpBadCrc;
        stEvent[`DLRX_ST_DUP]    = tlpDup;
        stEvent[`DLRX_ST_AHEAD]  = tlpAhead;
        stEvent[`DLRX_ST_FRAME]  = frameErr;
        stEvent[`DLRX_ST_ACKTO]  = latExpire && !needNak;
        stEvent[`DLRX_ST_PM]     = powerPacketReceived;
        stEvent[`DLRX_ST_FC]     = creditPacketReceived;
    end

    // an event in the cycle of its clear survives: set has priority
    assign status_d = (status_q & ~(wrClear ? pwdata[`DLRX_ST_WIDTH-1:0] : '0)) | stEvent;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= '0;
            irq      <= 1'b0;
        end else if (clkEn) begin
            status_q <= status_d;
            irq      <= |(status_d & irqEn_q);
        end
    end

endmodule

// ### tb/dlrx_status_monitor_chk.sv
// port-level assertions of the receive status monitor
`include "dlrx_params.svh"
module dlrx_status_monitor_chk (
    input wire logic                               clk_sys,
    input wire logic                               reset_n,
    input wire logic                               rxDllpValid,
    input wire logic [7:0]                         rxDllpType,
    input wire logic                               rxTlpEnd,
    input wire logic                               rxTlpNullified,
    input wire logic                               rxTlpCrcOk,
    input wire logic                               rxFrameError,
    input wire logic                               ackTxReq,
    input wire logic                               ackTxNak,
    input wire logic                               tlpForward,
    input wire logic                               rxPortError,
    input wire logic                               retrainReq,
    input wire logic [`DLRX_OBS_MSB:`DLRX_OBS_LSB] obsBus
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire logic fcIn = rxDllpValid && !rxDllpType[3]
        && (rxDllpType[7:4] inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE});
    wire logic pmIn = rxDllpValid && rxDllpType[7:3] == 5'h04
        && (rxDllpType[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4});
    wire logic crcBad = rxTlpEnd && !rxTlpNullified && !rxTlpCrcOk;

    AST_TIMER_EXPIRY: assert property (
        $rose(obsBus[297]) |-> $past(obsBus[296]) ##[0:2] obsBus[298])
        else $error("ack timeout without running timer or request");
    AST_REQ_MIRROR: assert property (obsBus[298] == $past(ackTxReq))
        else $error("request bit does not follow pending request");
    AST_NAK_ON_CRC: assert property (crcBad |=> ##[0:1] (ackTxReq && ackTxNak))
        else $error("no negative ack after crc failure");
    AST_PM_RX: assert property (
        pmIn |=> obsBus[300] && !obsBus[301] && obsBus[308:306] == $past(rxDllpType[2:0]))
        else $error("power packet report wrong");
    AST_FC_RX: assert property (fcIn |=> obsBus[301]
        && obsBus[305:302] == $past(rxDllpType[7:4]) && obsBus[308:306] == $past(rxDllpType[2:0]))
        else $error("credit packet report wrong");
    AST_NULL_ONLY: assert property (
        rxTlpEnd && rxTlpNullified |=> obsBus[309] && obsBus[313:310] == 4'h0 && !tlpForward)
        else $error("nullified packet report wrong");
    AST_CRC_FLAG: assert property (crcBad |=> obsBus[310] && rxPortError && !tlpForward)
        else $error("crc failure report wrong");
    AST_FWD_PAIR: assert property (tlpForward == obsBus[311])
        else $error("forward and good flag disagree");
    AST_DUP_SILENT: assert property (
        obsBus[312] && !obsBus[314] |-> !rxPortError && !tlpForward)
        else $error("duplicate reported as error or forwarded");
    AST_AHEAD_ERR: assert property (obsBus[313] |-> rxPortError && !tlpForward)
        else $error("sequence ahead without port error");
    AST_FRAME: assert property (
        rxFrameError |=> obsBus[314] && rxPortError && retrainReq)
        else $error("framing error report wrong");

    COV_TIMEOUT: cover property ($rose(obsBus[297]));
    COV_NAK: cover property (ackTxReq && ackTxNak);
    COV_DUP: cover property (obsBus[312]);
    COV_FRAME: cover property (retrainReq);
endmodule

// ### tb/dlrx_phy_model.sv
// stand-in for the receive physical layer, ack transmitter and retry buffer
module dlrx_phy_model (
    input  wire logic        clk_sys,
    output logic             rxDllpValid,
    output logic      [7:0]  rxDllpType,
    output logic             rxTlpEnd,
    output logic             rxTlpNullified,
    output logic             rxTlpCrcOk,
    output logic      [11:0] rxTlpSeq,
    output logic             rxFrameError,
    output logic             ackTxDone,
    output logic             retryStore,
    output logic             retryRelease
);
    initial begin
        {rxDllpValid, rxTlpEnd, rxFrameError, ackTxDone, retryStore, retryRelease} = 6'h0;
        {rxDllpType, rxTlpNullified, rxTlpCrcOk, rxTlpSeq} = 22'h3FFFFF;
    end
    // qualifiers flip once the strobe drops so a late read never sees the old value
    task automatic dllp(input logic [7:0] t);
        @(posedge clk_sys);
        rxDllpValid <= 1'h1;
        rxDllpType  <= t;
        @(posedge clk_sys);
        rxDllpValid <= 1'h0;
        rxDllpType  <= ~t;
    endtask
    task automatic tlp(input logic nul, input logic ok, input logic [11:0] s);
        @(posedge clk_sys);
        {rxTlpEnd, rxTlpNullified, rxTlpCrcOk, rxTlpSeq} <= {1'h1, nul, ok, s};
        @(posedge clk_sys);
        {rxTlpEnd, rxTlpNullified, rxTlpCrcOk, rxTlpSeq} <= {1'h0, ~nul, ~ok, ~s};
    endtask
    task automatic strobe(input logic frame);
        @(posedge clk_sys);
        {rxFrameError, ackTxDone} <= {frame, ~frame};
        @(posedge clk_sys);
        {rxFrameError, ackTxDone} <= 2'h0;
    endtask
    task automatic retry(input logic st, input int n);
        @(posedge clk_sys);
        {retryStore, retryRelease} <= {st, ~st};
        repeat (n) @(posedge clk_sys);
        {retryStore, retryRelease} <= 2'h0;
    endtask
endmodule

// ### tb/dlrx_status_monitor_test.sv
// self-checking bench of the receive status monitor
`include "dlrx_params.svh"
module dlrx_status_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic          clk_sys = 1'h0;
    logic          reset_n = 1'h0;
    logic          clkEn   = 1'h1;
    logic          psel    = 1'h0;
    logic          penable = 1'h0;
    logic          pwrite  = 1'h0;
    logic [7:0]    paddr   = 8'h00;
    logic [31:0]   pwdata  = 32'h0;
    wire  [31:0]   prdata;
    wire           pready, pslverr, irq, ackTxReq, ackTxNak, tlpForward, rxPortError;
    wire           retrainReq, rxDllpValid, rxTlpEnd, rxTlpNullified, rxTlpCrcOk;
    wire           rxFrameError, ackTxDone, retryStore, retryRelease;
    wire  [7:0]    rxDllpType;
    wire  [11:0]   rxTlpSeq;
    wire  [319:296] obsBus;
    int            n_mismatch = 0;
    int            checks     = 0;
    int            n, k;
    logic [11:0]   expSeq, s;
    logic [31:0]   r;
    logic          e;
    logic [2:0]    c;
    logic [8:0]    ev;
    logic [3:0]    fcCodes [9] = '{4'h4, 4'h5, 4'h6, 4'hC, 4'hD, 4'hE, 4'h8, 4'h9, 4'hA};
    logic [2:0]    pmCodes [4] = '{3'h0, 3'h1, 3'h3, 3'h4};

    dlrx_status_monitor i_dlrx_status_monitor (.*);
    dlrx_phy_model      phy (.*);

    always #5 clk_sys = ~clk_sys;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checks++;
        if (g !== ex) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", nm, ex, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk_sys);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (n >= 16) n_mismatch++;
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(w, a, d);
        if (!w) chk("read data", d, r);
        chk("slave error", 32'(ee), 32'(e));
    endtask
    // bit 7 port error, bit 6 forward, bits 5:0 the packet flags from 314 down to 309
    function automatic logic [7:0] flags(input int kind);
        case (kind)
            0: flags = 8'h44;
            1: flags = 8'h08;
            2: flags = 8'h90;
            3: flags = 8'h82;
            default: flags = 8'h01;
        endcase
    endfunction
    task automatic settle(input int cyc);
        repeat (cyc) @(posedge clk_sys);
        #1;
    endtask

    initial begin
        #500us;
        n_mismatch++;
        report_and_stop;
    end

    initial begin
        void'($urandom(32'h5622D1A5));
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'h1;
        acc(1'h0, `DLRX_REG_CTRL, 32'h1, 1'h0);
        acc(1'h0, `DLRX_REG_ACKLAT, 32'h100, 1'h0);
        acc(1'h0, `DLRX_REG_IRQEN, 32'h0, 1'h0);
        acc(1'h0, 8'h1C, 32'h0, 1'h1);
        acc(1'h1, `DLRX_REG_STATUS, 32'hFF, 1'h1);
        acc(1'h0, `DLRX_REG_CLEAR, 32'h0, 1'h1);
        acc(1'h0, `DLRX_REG_STATUS, 32'h0, 1'h0);
        acc(1'h1, `DLRX_REG_ACKLAT, 32'h4, 1'h0);
        acc(1'h1, `DLRX_REG_IRQEN, 32'h2, 1'h0);
        phy.tlp(1'h0, 1'h1, 12'h000);
        #1;
        chk("good forward", 32'h3, {30'h0, obsBus[311], tlpForward});
        // the timer bit follows the registered state, one cycle after the packet flag
        settle(1);
        chk("ack timer", 32'h1, 32'(obsBus[296]));
        for (n = 0; obsBus[297] !== 1'h1 && n < 40; n++) settle(1);
        chk("ack timeout", 32'h1, 32'(obsBus[297]));
        settle(2);
        chk("ack pending", 32'h1, 32'(obsBus[299:298]));
        phy.strobe(1'h0);
        settle(2);
        chk("ack released", 32'h0, 32'(obsBus[298]));
        phy.tlp(1'h0, 1'h0, 12'h001);
        #1;
        chk("crc error", 32'h3, {30'h0, obsBus[310], rxPortError});
        settle(1);
        chk("irq raised", 32'h1, 32'(irq));
        settle(1);
        chk("nak pending", 32'h3, 32'(obsBus[299:298]));
        acc(1'h1, `DLRX_REG_CLEAR, 32'h2, 1'h0);
        settle(1);
        chk("irq cleared", 32'h0, 32'(irq));
        acc(1'h1, `DLRX_REG_IRQEN, 32'h0, 1'h0);
        phy.tlp(1'h0, 1'h0, 12'h001);
        settle(2);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'h0, `DLRX_REG_STATUS, 32'h0);
        chk("crc status", 32'h1, 32'(r[1]));
        phy.strobe(1'h0);
        expSeq = 12'h001;
        for (int i = 0; i < 60; i++) begin
            k = $urandom % 5;
            s = 12'($urandom);
            if (k == 0) s = expSeq;
            if (k == 1) s = expSeq - 12'(1 + $urandom % 8);
            if (k == 2) s = expSeq + 12'(1 + $urandom % 64);
            phy.tlp(k == 4, k != 3 && (k != 4 || s[0]), s);
            #1;
            chk("rx flags", 32'(flags(k)), {24'h0, rxPortError, tlpForward, obsBus[314:309]});
            if (k == 0) expSeq++;
        end
        acc(1'h0, `DLRX_REG_SEQ, 32'(expSeq), 1'h0);
        phy.strobe(1'h1);
        #1;
        chk("framing", 32'h7, {29'h0, obsBus[314], rxPortError, retrainReq});
        for (int i = 0; i < 13; i++) begin
            c = (i == 0) ? 3'h7 : 3'($urandom);
            if (i < 9) begin
                phy.dllp({fcCodes[i], 1'h0, c});
                ev = {c, fcCodes[i], 2'h2};
            end else begin
                phy.dllp({5'h04, pmCodes[i-9]});
                ev = {pmCodes[i-9], 4'h0, 2'h1};
            end
            #1;
            chk("link packet", 32'(ev), 32'(obsBus[308:300]));
        end
        phy.retry(1'h1, 33);
        settle(3);
        chk("retry saturated", 32'h1F, 32'(obsBus[319:315]));
        phy.retry(1'h0, 3);
        settle(3);
        chk("retry drained", 32'h1E, 32'(obsBus[319:315]));
        phy.retry(1'h0, 30);
        settle(3);
        chk("retry empty", 32'h0, 32'(obsBus[319:315]));
        // with the clock enable low the counter must ignore stored packets
        @(posedge clk_sys) clkEn <= 1'h0;
        phy.retry(1'h1, 4);
        settle(3);
        chk("retry frozen", 32'h0, 32'(obsBus[319:315]));
        @(posedge clk_sys) clkEn <= 1'h1;
        settle(3);
        chk("retry thawed", 32'h0, 32'(obsBus[319:315]));
        report_and_stop;
    end
endmodule

bind dlrx_status_monitor dlrx_status_monitor_chk i_chk (.*);
